// [common/udbc_pkg.sv]
// Purpose: Shared constants and types for the 4-bit up/down counter
// Assumes: One 50 MHz system clock
// Notes: Count pins are strobes sampled in the clock domain
package udbc_pkg;
    localparam int COUNT_WIDTH = 4;
    localparam logic [3:0] COUNT_RESET = 4'h0;
    localparam logic [3:0] COUNT_MAX = 4'hF;
    localparam logic [3:0] COUNT_MIN = 4'h0;
    // Idle pin levels {up, down, clear, load_n}; avoids a false edge after reset
    localparam logic [3:0] SYNC_IDLE = 4'hD;
    localparam logic EDGE_IDLE = 1'b1;
    localparam real CLK_PERIOD_NS = 20.0;

    typedef struct packed {
        logic upClockIn;
        logic downClockIn;
        logic masterClear;
        logic presetLoad_n;
        logic [3:0] presetData;
    } udbc_ctrl_t;

    typedef struct packed {
        logic [3:0] count;
        logic carryOut_n;
        logic borrowOut_n;
    } udbc_stat_t;

    typedef enum logic [1:0] {
        UDBC_HOLD,
        UDBC_UP,
        UDBC_DOWN
    } udbc_op_t;
endpackage

// [dv/udbc_counter_tb.sv]
// Purpose: Self-checking bench for the up/down counter
// Assumes: Three-edge input latency
// Notes: Levels held four cycles so the synchroniser sees them
`timescale 1ns/1ps
module udbc_counter_tb;
    logic clk;
    logic rst;
    udbc_pkg::udbc_ctrl_t ctrl;
    udbc_pkg::udbc_stat_t stat;
    logic [3:0] upper;
    int miscompares = 0;
    int numChecks = 0;
    int cycles = 0;
    udbc_counter DUT (.clk(clk), .rst(rst), .ctrl(ctrl), .stat(stat));
    udbc_stage_model STAGE (.clk(clk), .rst(rst), .upIn(stat.carryOut_n),
        .downIn(stat.borrowOut_n), .count(upper));
    initial
    begin
        clk = 1'h0;
        forever #(udbc_pkg::CLK_PERIOD_NS / 2.0) clk = ~clk;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chkCount(input logic [3:0] got, input logic [3:0] exp);
        numChecks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chkBit(input logic got, input logic exp);
        numChecks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Low phase then rise; terminal flag judged while the pin is low
    task automatic pulse(input logic up, input logic expTc);
        if (up)
            ctrl.upClockIn = 1'h0;
        else
            ctrl.downClockIn = 1'h0;
        step(4);
        chkBit(up ? stat.carryOut_n : stat.borrowOut_n, expTc);
        ctrl.upClockIn = 1'h1;
        ctrl.downClockIn = 1'h1;
        step(4);
    endtask
    task automatic endSim();
        $display("checks %0d mismatches %0d", numChecks, miscompares);
        if (miscompares == 0 && numChecks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles > 400)
        begin
            miscompares++;
            endSim();
        end
    end
    task automatic testClearLoad();
        step(5);
        chkCount(stat.count, 4'h0);
        ctrl.masterClear = 1'h0;
        step(5);
        chkCount(stat.count, 4'hA);
        $display("clear and load done");
    endtask
    task automatic testLoadOverCount();
        ctrl.presetData = 4'hE;
        pulse(1'h1, 1'h1);
        chkCount(stat.count, 4'hE);
        ctrl.presetLoad_n = 1'h1;
        $display("load over count done");
    endtask
    task automatic testCountUp();
        pulse(1'h1, 1'h1);
        chkCount(stat.count, 4'hF);
        pulse(1'h1, 1'h0);
        chkCount(stat.count, 4'h0);
        chkCount(upper, 4'h1);
        $display("count up done");
    endtask
    task automatic testCountDown();
        pulse(1'h0, 1'h0);
        chkCount(stat.count, 4'hF);
        chkCount(upper, 4'h0);
        $display("count down done");
    endtask
    // Each clock rises while the other is low, then both rise together: no count
    task automatic testRefused();
        ctrl.upClockIn = 1'h0;
        ctrl.downClockIn = 1'h0;
        step(4);
        chkBit(stat.carryOut_n, 1'h0);
        chkBit(stat.borrowOut_n, 1'h1);
        ctrl.downClockIn = 1'h1;
        step(4);
        chkCount(stat.count, 4'hF);
        ctrl.downClockIn = 1'h0;
        ctrl.upClockIn = 1'h1;
        step(4);
        chkCount(stat.count, 4'hF);
        chkBit(stat.carryOut_n, 1'h1);
        ctrl.upClockIn = 1'h0;
        step(4);
        ctrl.upClockIn = 1'h1;
        ctrl.downClockIn = 1'h1;
        step(4);
        chkCount(stat.count, 4'hF);
        chkCount(upper, 4'h2);
        $display("refused edges done");
    endtask
    // Clear mid-run overrides a down edge; borrow still reaches the next stage
    task automatic testClearOverCount();
        ctrl.masterClear = 1'h1;
        ctrl.downClockIn = 1'h0;
        step(4);
        chkCount(stat.count, 4'h0);
        chkBit(stat.borrowOut_n, 1'h0);
        ctrl.downClockIn = 1'h1;
        step(4);
        chkCount(stat.count, 4'h0);
        chkCount(upper, 4'h1);
        ctrl.masterClear = 1'h0;
        step(4);
        chkCount(stat.count, 4'h0);
        $display("clear over count done");
    endtask
    initial
    begin
        rst = 1'h1;
        ctrl = '{1'h1, 1'h1, 1'h1, 1'h0, 4'hA};
        step(3);
        rst = 1'h0;
        testClearLoad();
        testLoadOverCount();
        testCountUp();
        testCountDown();
        testRefused();
        testClearOverCount();
        endSim();
    end
endmodule

// [dv/udbc_stage_model.sv]
// Purpose: Next counter stage fed by carry and borrow
// Assumes: Edges seen in clk domain
// Notes: Upper nibble of a cascade
`timescale 1ns/1ps
module udbc_stage_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic upIn,
    input wire logic downIn,
    output logic [3:0] count
);
    logic upPrev;
    logic downPrev;
    always_ff @(posedge clk)
    begin
        upPrev <= upIn;
        downPrev <= downIn;
        if (rst)
            count <= 4'h0;
        else if (upIn && !upPrev && downIn && downPrev)
            count <= count + 4'h1;
        else if (downIn && !downPrev && upIn && upPrev)
            count <= count - 4'h1;
    end
endmodule

// [rtl/udbc_counter.sv]
// Purpose: Presettable 4-bit modulo-16 up/down counter with carry and borrow
// Assumes: Count clocks, clear and load arrive asynchronously; all sampled in clk domain
// Notes: Clear and load act one edge after the two-flop synchroniser latency, not instantly
`timescale 1ns/1ps
module udbc_counter (
    input wire logic clk,
    input wire logic rst,
    input wire udbc_pkg::udbc_ctrl_t ctrl,
    output udbc_pkg::udbc_stat_t stat
);
    logic [3:0] syncLevels;
    logic upLvl;
    logic downLvl;
    logic clearLvl;
    logic loadLvl_n;
    logic upPrev;
    logic downPrev;
    logic [3:0] count;
    logic [3:0] next_count;
    logic next_upPrev;
    logic next_downPrev;
    logic carryOut_n;
    logic borrowOut_n;
    logic next_carryOut_n;
    logic next_borrowOut_n;
    udbc_pkg::udbc_op_t op;

    // Synchronise the up clock, down clock, clear and load inputs; presetData is used unsynchronised
    udbc_sync #(.WIDTH(4)) u_sync (
        .clk(clk),
        .rst(rst),
        .din({ctrl.upClockIn, ctrl.downClockIn, ctrl.masterClear, ctrl.presetLoad_n}),
        .resetValue(udbc_pkg::SYNC_IDLE),
        .dout(syncLevels)
    );

    assign upLvl = syncLevels[3];
    assign downLvl = syncLevels[2];
    assign clearLvl = syncLevels[1];
    assign loadLvl_n = syncLevels[0];

    function automatic logic rose(input logic now, input logic prev);
        rose = now & ~prev;
    endfunction

    // Active-low terminal flag, shared by carry and borrow
    function automatic logic terminalN(input logic [3:0] value, input logic [3:0] target, input logic clockLvl);
        terminalN = ~((value == target) && !clockLvl);
    endfunction

    always_comb
    begin
        op = udbc_pkg::UDBC_HOLD;
        // Count only when the other clock is held high
        // Both rising together is the both-high no-change case, not a count
        if (rose(upLvl, upPrev) && downLvl && downPrev)
            op = udbc_pkg::UDBC_UP;
        else if (rose(downLvl, downPrev) && upLvl && upPrev)
            op = udbc_pkg::UDBC_DOWN;
    end

    always_comb
    begin
        next_upPrev = upLvl;
        next_downPrev = downLvl;
        next_count = count;
        if (clearLvl)
            next_count = udbc_pkg::COUNT_RESET;
        else if (!loadLvl_n)
            next_count = ctrl.presetData;
        else
        begin
            case (op)
                udbc_pkg::UDBC_UP: next_count = count + 4'h1;
                udbc_pkg::UDBC_DOWN: next_count = count - 4'h1;
                default: next_count = count;
            endcase
        end
        // Terminal counts use the synchronised clock level so they track the count
        next_carryOut_n = terminalN(next_count, udbc_pkg::COUNT_MAX, upLvl);
        next_borrowOut_n = terminalN(next_count, udbc_pkg::COUNT_MIN, downLvl);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            count <= udbc_pkg::COUNT_RESET;
            upPrev <= udbc_pkg::EDGE_IDLE;
            downPrev <= udbc_pkg::EDGE_IDLE;
            carryOut_n <= 1'b1;
            borrowOut_n <= 1'b1;
        end
        else
        begin
            count <= next_count;
            upPrev <= next_upPrev;
            downPrev <= next_downPrev;
            carryOut_n <= next_carryOut_n;
            borrowOut_n <= next_borrowOut_n;
        end
    end

    assign stat.count = count;
    assign stat.carryOut_n = carryOut_n;
    assign stat.borrowOut_n = borrowOut_n;

    property p_clear;
        @(posedge clk) disable iff (rst) clearLvl |=> (count == 4'h0);
    endproperty
    a_clear: assert property (p_clear) else $error("Clear did not zero count");

    property p_load;
        @(posedge clk) disable iff (rst) (!clearLvl && !loadLvl_n) |=> (count == $past(ctrl.presetData));
    endproperty
    a_load: assert property (p_load) else $error("Load did not preset count");

    property p_up;
        @(posedge clk) disable iff (rst)
            (!clearLvl && loadLvl_n && upLvl && !upPrev && downLvl && downPrev)
            |=> (count == $past(count) + 4'h1);
    endproperty
    a_up: assert property (p_up) else $error("Up edge did not increment");

    property p_down;
        @(posedge clk) disable iff (rst)
            (!clearLvl && loadLvl_n && downLvl && !downPrev && upLvl && upPrev)
            |=> (count == $past(count) - 4'h1);
    endproperty
    a_down: assert property (p_down) else $error("Down edge did not decrement");

    property p_wrap;
        @(posedge clk) disable iff (rst)
            (!clearLvl && loadLvl_n && count == 4'hF && upLvl && !upPrev && downLvl && downPrev)
            |=> (count == 4'h0);
    endproperty
    a_wrap: assert property (p_wrap) else $error("Count did not wrap to zero");

    property p_stable;
        @(posedge clk) disable iff (rst)
            (!clearLvl && loadLvl_n && !(upLvl && !upPrev) && !(downLvl && !downPrev)) |=> $stable(count);
    endproperty
    a_stable: assert property (p_stable) else $error("Count changed without edge");

    property p_carry;
        @(posedge clk) disable iff (rst) 1'b1 |=> (carryOut_n == !(count == 4'hF && !$past(upLvl)));
    endproperty
    a_carry: assert property (p_carry) else $error("Carry output wrong");

    property p_borrow;
        @(posedge clk) disable iff (rst) 1'b1 |=> (borrowOut_n == !(count == 4'h0 && !$past(downLvl)));
    endproperty
    a_borrow: assert property (p_borrow) else $error("Borrow output wrong");

    property p_both_rise;
        @(posedge clk) disable iff (rst)
            (!clearLvl && loadLvl_n && upLvl && !upPrev && downLvl && !downPrev) |=> $stable(count);
    endproperty
    a_both_rise: assert property (p_both_rise) else $error("Count moved on a joint rise");

    property p_up_refused;
        @(posedge clk) disable iff (rst)
            (!clearLvl && loadLvl_n && upLvl && !upPrev && !downLvl) |=> $stable(count);
    endproperty
    a_up_refused: assert property (p_up_refused) else $error("Up edge counted with down low");

    property p_down_refused;
        @(posedge clk) disable iff (rst)
            (!clearLvl && loadLvl_n && downLvl && !downPrev && !upLvl) |=> $stable(count);
    endproperty
    a_down_refused: assert property (p_down_refused) else $error("Down edge counted with up low");

    property p_wrap_down;
        @(posedge clk) disable iff (rst)
            (!clearLvl && loadLvl_n && count == udbc_pkg::COUNT_MIN && downLvl && !downPrev && upLvl && upPrev)
            |=> (count == udbc_pkg::COUNT_MAX);
    endproperty
    a_wrap_down: assert property (p_wrap_down) else $error("Count did not wrap to fifteen");

    property p_clear_over_load;
        @(posedge clk) disable iff (rst)
            (clearLvl && !loadLvl_n) |=> (count == udbc_pkg::COUNT_RESET);
    endproperty
    a_clear_over_load: assert property (p_clear_over_load) else $error("Load beat clear");

    property p_clear_hold;
        @(posedge clk) disable iff (rst)
            (clearLvl && $past(clearLvl)) |-> (count == udbc_pkg::COUNT_RESET);
    endproperty
    a_clear_hold: assert property (p_clear_hold) else $error("Count left zero during clear");

    property p_carry_at_max;
        @(posedge clk) disable iff (rst)
            !carryOut_n |-> (count == udbc_pkg::COUNT_MAX);
    endproperty
    a_carry_at_max: assert property (p_carry_at_max) else $error("Carry low away from fifteen");

    property p_borrow_at_min;
        @(posedge clk) disable iff (rst)
            !borrowOut_n |-> (count == udbc_pkg::COUNT_MIN);
    endproperty
    a_borrow_at_min: assert property (p_borrow_at_min) else $error("Borrow low away from zero");

    property p_carry_idle;
        @(posedge clk) disable iff (rst)
            upLvl |=> carryOut_n;
    endproperty
    a_carry_idle: assert property (p_carry_idle) else $error("Carry low with up clock high");

    property p_borrow_idle;
        @(posedge clk) disable iff (rst)
            downLvl |=> borrowOut_n;
    endproperty
    a_borrow_idle: assert property (p_borrow_idle) else $error("Borrow low with down clock high");

    property p_sync_delay;
        @(posedge clk) disable iff (rst)
            (!$past(rst) && !$past(rst, 2))
            |-> (clearLvl == $past(ctrl.masterClear, 2)) && (loadLvl_n == $past(ctrl.presetLoad_n, 2));
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("Clear or load not two flops late");
endmodule

// [rtl/udbc_sync.sv]
// Purpose: Two-flop synchroniser for a group of level inputs
// Assumes: Inputs may be asynchronous to clk
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
module udbc_sync #(
    parameter int WIDTH = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] din,
    input wire logic [WIDTH-1:0] resetValue,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_dout;

    always_comb
    begin
        next_stage1 = din;
        next_dout = stage1;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            stage1 <= resetValue;
            dout <= resetValue;
        end
        else
        begin
            stage1 <= next_stage1;
            dout <= next_dout;
        end
    end
endmodule
